/* File: rtl/wtiu_top.sv */
`timescale 1ns/1ps
module wtiu_top
    import wtiu_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [31:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [31:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Watch clock sources
    input wire logic subclk,
    input wire logic brg_clk,
    input wire logic rate_timer_enable,
    // Interrupt requests
    output logic watch_irq,
    output logic interval_irq
);

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    function automatic logic [10:0] tap_mask(input logic [2:0] sel);
        logic [10:0] m;
        m = WTIU_PRESC_FULL >> (3'(WTIU_TAP_MAX_SHIFT) - sel);
        return m;
    endfunction

    function automatic logic [1:0] addr_kind(input logic [31:0] a);
        logic [1:0] k;
        k = 2'b00;
        if (a[31:2] == WTIU_MODE_ADDR[31:2]) begin
            k = 2'b00;
        end else if (a[31:2] == WTIU_SET_ADDR[31:2]) begin
            k = 2'b01;
        end else if (a[31:2] == WTIU_CLR_ADDR[31:2]) begin
            k = 2'b10;
        end else begin
            k = 2'b11;
        end
        return k;
    endfunction

    function automatic logic addr_hit(input logic [31:0] a);
        logic h;
        h = (a[31:2] == WTIU_MODE_ADDR[31:2]) || (a[31:2] == WTIU_SET_ADDR[31:2])
            || (a[31:2] == WTIU_CLR_ADDR[31:2]) || (a[31:2] == WTIU_STAT_ADDR[31:2]);
        return h;
    endfunction

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    wtiu_mode_t watch_mode_reg;
    wtiu_mode_t next_mode;
    logic [10:0] prescaler;
    logic [10:0] next_prescaler;
    logic [4:0] counter;
    logic [4:0] next_counter;
    logic aw_held;
    logic w_held;
    logic [31:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic sub_rise;
    logic brg_rise;
    logic tick;
    logic run;
    logic cnt_event;
    logic [2:0] interval_sel;
    logic [10:0] interval_mask;
    logic [4:0] watch_mask;
    logic interval_fire;
    logic watch_fire;
    logic aw_take;
    logic w_take;
    logic wr_do;
    logic wr_mapped;
    logic wr_lane0;
    logic [1:0] wr_kind;
    logic [7:0] wr_byte;
    logic ar_take;
    wtiu_status_t status;

    // ----------------------------------------
    // Watch clock edge detection
    // ----------------------------------------
    wtiu_edge_sync u_sub_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(subclk),
        .rise(sub_rise)
    );

    wtiu_edge_sync u_brg_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(brg_clk),
        .rise(brg_rise)
    );

    // The rate timer only matters on the main-clock path, so its setting
    // cannot disturb a subclock-driven watch.
    assign tick = watch_mode_reg.clock_source_sel ? (brg_rise & rate_timer_enable) : sub_rise;

    // ----------------------------------------
    // Prescaler
    // ----------------------------------------
    // Selects are sampled live; software keeps them steady while running.
    assign interval_sel = {watch_mode_reg.interval_sel_hi, watch_mode_reg.interval_sel_mid,
                           watch_mode_reg.interval_sel_lo};
    assign interval_mask = tap_mask(interval_sel);

    always_comb begin
        next_prescaler = prescaler;
        if (!watch_mode_reg.watch_enable) begin
            next_prescaler = WTIU_PRESC_ZERO;
        end else if (tick) begin
            next_prescaler = prescaler + WTIU_PRESC_ONE;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prescaler <= WTIU_PRESC_ZERO;
        end else begin
            prescaler <= next_prescaler;
        end
    end

    // Fires once per 2^(4+sel) watch clock periods, independent of counter_run
    assign interval_fire = watch_mode_reg.watch_enable & tick
                           & ((prescaler & interval_mask) == interval_mask);

    // ----------------------------------------
    // 5-bit watch counter
    // ----------------------------------------
    assign run = watch_mode_reg.watch_enable & watch_mode_reg.counter_run;

    // High period bit counts fw itself, low counts fw/2^9 carries
    assign cnt_event = watch_mode_reg.watch_period_sel_hi ? tick
                       : (tick & ((prescaler & WTIU_PRESC_DIV9) == WTIU_PRESC_DIV9));

    always_comb begin
        next_counter = counter;
        if (!run) begin
            // Prescaler keeps going if only counter_run dropped
            next_counter = WTIU_CNT_ZERO;
        end else if (cnt_event) begin
            next_counter = counter + WTIU_CNT_ONE;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            counter <= WTIU_CNT_ZERO;
        end else begin
            counter <= next_counter;
        end
    end

    // 00: 2^14, 01: 2^13, 10: 2^5, 11: 2^4
    assign watch_mask = watch_mode_reg.watch_period_sel_lo ? WTIU_CNT_HALF : WTIU_CNT_FULL;

    // Chain starts cleared, so the first request comes a full watch period after the enable
    assign watch_fire = run & cnt_event & ((counter & watch_mask) == watch_mask);

    // ----------------------------------------
    // Interrupt pulses
    // ----------------------------------------
    // Tick is already a one-cycle aclk pulse, so each request lasts one cycle.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            watch_irq <= 1'b0;
            interval_irq <= 1'b0;
        end else begin
            watch_irq <= watch_fire;
            interval_irq <= interval_fire;
        end
    end

    // ----------------------------------------
    // AXI4-Lite write path
    // ----------------------------------------
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign wr_do = aw_held && w_held && !s_axi_bvalid;
    assign wr_mapped = addr_hit(aw_addr);
    assign wr_kind = addr_kind(aw_addr);
    assign wr_lane0 = w_strb[0];
    assign wr_byte = w_data[7:0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= 32'h00000000;
        end else if (aw_take) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (wr_do) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end else if (w_take) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (wr_do) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= WTIU_RESP_OKAY;
        end else if (wr_do) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? WTIU_RESP_OKAY : WTIU_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // Mode register
    // ----------------------------------------
    // Set and clear aliases give atomic single-bit writes without a
    // read-modify-write race against other software.
    always_comb begin
        next_mode = watch_mode_reg;
        if (wr_do && wr_lane0) begin
            unique case (wr_kind)
                2'b00: next_mode = wtiu_mode_t'(wr_byte);
                2'b01: next_mode = wtiu_mode_t'(watch_mode_reg | wr_byte);
                2'b10: next_mode = wtiu_mode_t'(watch_mode_reg & ~wr_byte);
                2'b11: next_mode = watch_mode_reg;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            watch_mode_reg <= wtiu_mode_t'(WTIU_MODE_RESET);
        end else begin
            watch_mode_reg <= next_mode;
        end
    end

    // ----------------------------------------
    // AXI4-Lite read path
    // ----------------------------------------
    assign status.pad = 13'h0000;
    assign status.source_brg = watch_mode_reg.clock_source_sel;
    assign status.counting = run;
    assign status.prescaling = watch_mode_reg.watch_enable;
    assign status.counter = counter;
    assign status.prescaler = prescaler;

    assign s_axi_arready = !s_axi_rvalid;
    assign ar_take = s_axi_arvalid && s_axi_arready;

    always_comb begin
        next_rdata = 32'h00000000;
        next_rresp = WTIU_RESP_OKAY;
        if (s_axi_araddr[31:2] == WTIU_STAT_ADDR[31:2]) begin
            next_rdata = status;
        end else if (s_axi_araddr[31:2] == WTIU_MODE_ADDR[31:2]) begin
            next_rdata = {24'h000000, watch_mode_reg};
        end else if (!addr_hit(s_axi_araddr)) begin
            next_rresp = WTIU_RESP_SLVERR;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= WTIU_RESP_OKAY;
        end else if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

/* File: rtl/wtiu_pkg.sv */
package wtiu_pkg;

    // ----------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------
    localparam logic [31:0] WTIU_MODE_ADDR = 32'hfffff680;
    localparam logic [31:0] WTIU_SET_ADDR = 32'hfffff684;
    localparam logic [31:0] WTIU_CLR_ADDR = 32'hfffff688;
    localparam logic [31:0] WTIU_STAT_ADDR = 32'hfffff68c;
    localparam logic [7:0] WTIU_MODE_RESET = 8'h00;

    // ----------------------------------------
    // Bus responses
    // ----------------------------------------
    localparam logic [1:0] WTIU_RESP_OKAY = 2'b00;
    localparam logic [1:0] WTIU_RESP_SLVERR = 2'b10;

    // ----------------------------------------
    // Counter chain geometry
    // ----------------------------------------
    localparam int WTIU_PRESC_W = 11;
    localparam int WTIU_CNT_W = 5;
    localparam int WTIU_TAP_MAX_SHIFT = 7;
    localparam logic [10:0] WTIU_PRESC_ZERO = 11'h000;
    localparam logic [10:0] WTIU_PRESC_ONE = 11'h001;
    localparam logic [10:0] WTIU_PRESC_FULL = 11'h7ff;
    localparam logic [10:0] WTIU_PRESC_DIV9 = 11'h1ff;
    localparam logic [4:0] WTIU_CNT_ZERO = 5'h00;
    localparam logic [4:0] WTIU_CNT_ONE = 5'h01;
    localparam logic [4:0] WTIU_CNT_FULL = 5'h1f;
    localparam logic [4:0] WTIU_CNT_HALF = 5'h0f;
    localparam int WTIU_WATCH_CLOCK_FREQ_HZ = 32768;

    // ----------------------------------------
    // Mode register layout, bit 7 down to bit 0
    // ----------------------------------------
    typedef struct packed {
        logic clock_source_sel;
        logic interval_sel_hi;
        logic interval_sel_mid;
        logic interval_sel_lo;
        logic watch_period_sel_hi;
        logic watch_period_sel_lo;
        logic counter_run;
        logic watch_enable;
    } wtiu_mode_t;

    // ----------------------------------------
    // Status word layout
    // ----------------------------------------
    typedef struct packed {
        logic [12:0] pad;
        logic source_brg;
        logic counting;
        logic prescaling;
        logic [4:0] counter;
        logic [10:0] prescaler;
    } wtiu_status_t;

endpackage

/* File: rtl/wtiu_edge_sync.sv */
`timescale 1ns/1ps
module wtiu_edge_sync
    import wtiu_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Asynchronous clock pin
    input wire logic async_in,
    // One-cycle pulse on each rising edge
    output logic rise
);

    logic meta;
    logic stable;
    logic prev;

    // ----------------------------------------
    // Two-stage synchroniser, then edge detect
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta <= 1'b0;
            stable <= 1'b0;
            prev <= 1'b0;
        end else begin
            meta <= async_in;
            stable <= meta;
            prev <= stable;
        end
    end

    // Only the second and third stages are looked at
    assign rise = stable & ~prev;

endmodule

/* File: bench/wtiu_assertions.sv */
`timescale 1ns/1ps
module wtiu_assertions
    import wtiu_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Timer pins and requests
    input wire logic subclk,
    input wire logic brg_clk,
    input wire logic watch_irq,
    input wire logic interval_irq
);
    logic sub_q, brg_q;
    logic [3:0] since_edge;
    // Bus gating is ignored here, so the edge window is only an upper bound
    wire pin_rise = (subclk && !sub_q) || (brg_clk && !brg_q);
    wire ar_hit = s_axi_arvalid && s_axi_arready;
    wire ar_map = (s_axi_araddr == WTIU_MODE_ADDR) || (s_axi_araddr == WTIU_SET_ADDR) ||
        (s_axi_araddr == WTIU_CLR_ADDR) || (s_axi_araddr == WTIU_STAT_ADDR);

    always_ff @(posedge aclk) begin
        sub_q <= subclk;
        brg_q <= brg_clk;
        if (!aresetn || (!pin_rise && since_edge != 4'hf)) since_edge <= aresetn ? since_edge + 4'h1 : 4'hf;
        else if (pin_rise) since_edge <= 4'h0;
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_RESET_IDLE: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !watch_irq
        && !interval_irq && s_axi_arready) else $error("outputs not idle after reset");
    AST_WATCH_PULSE: assert property (watch_irq |=> !watch_irq) else $error("watch request too long");
    AST_IVL_PULSE: assert property (interval_irq |=> !interval_irq) else $error("interval request too long");
    AST_IVL_CAUSE: assert property (interval_irq |-> since_edge <= 4'h8)
        else $error("interval request without clock edge");
    AST_WATCH_CAUSE: assert property (watch_irq |-> since_edge <= 4'h8)
        else $error("watch request without clock edge");
    AST_RD_ANSWER: assert property (ar_hit |=> s_axi_rvalid) else $error("read not answered");
    AST_RD_UNMAPPED: assert property (ar_hit && !ar_map |=> s_axi_rresp == WTIU_RESP_SLVERR
        && s_axi_rdata == 32'h0) else $error("unmapped read wrong");
    AST_RD_MAPPED: assert property (ar_hit && ar_map |=> s_axi_rresp == WTIU_RESP_OKAY
        && s_axi_rdata[31:19] == 13'h0) else $error("mapped read wrong");
    AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read held");
    AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("resp held");

    cover property (watch_irq);
    cover property (interval_irq);
    cover property (s_axi_bvalid && s_axi_bresp == WTIU_RESP_SLVERR);
endmodule

/* File: bench/tb_watch_timer_interval_unit.sv */
`timescale 1ns/1ps
module tb_watch_timer_interval_unit;
    import wtiu_pkg::*;
    localparam logic [31:0] MODE = WTIU_MODE_ADDR;
    localparam logic [31:0] STAT = WTIU_STAT_ADDR;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic subclk, brg_clk, rate_timer_enable, watch_irq, interval_irq;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    int error_cnt, compares, wi_cnt, ii_cnt, b;

    wtiu_top dut (.*);

    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    // Counted on the falling edge so the pulses are settled
    always @(negedge aclk) begin
        if (watch_irq === 1'b1) wi_cnt++;
        if (interval_irq === 1'b1) ii_cnt++;
    end

    // ----
    // Shared tasks
    // ----
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        chk({30'h0, got}, {30'h0, exp});
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] v, output logic [1:0] rs);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
            if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] rs);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        v = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
        rd(a, d, r);
        chk(d, exp);
        chk_resp(r, WTIU_RESP_OKAY);
    endtask

    // Each pulse is wide enough for the two-stage synchroniser
    task automatic tick(input int n, input bit brg);
        repeat (n) begin
            @(posedge aclk);
            if (brg) brg_clk <= 1'b1;
            else subclk <= 1'b1;
            repeat (3) @(posedge aclk);
            brg_clk <= 1'b0;
            subclk <= 1'b0;
            repeat (2) @(posedge aclk);
        end
        repeat (6) @(posedge aclk);
    endtask

    // ----
    // Scenarios
    // ----
    task automatic t_reset;
        rdchk(MODE, 32'h0);
        rdchk(STAT, 32'h0);
        rd(32'hfffff690, d, r);
        chk(d, 32'h0);
        chk_resp(r, WTIU_RESP_SLVERR);
    endtask

    task automatic t_regs;
        wr(MODE, 32'hfc, r);
        chk_resp(r, WTIU_RESP_OKAY);
        rdchk(MODE, 32'hfc);
        wr(WTIU_CLR_ADDR, 32'h84, r);
        rdchk(MODE, 32'h78);
        wr(WTIU_SET_ADDR, 32'h02, r);
        rdchk(MODE, 32'h7a);
        wr(32'hfffff690, 32'hff, r);
        chk_resp(r, WTIU_RESP_SLVERR);
        rdchk(MODE, 32'h7a);
        // Byte lane 0 off: the write is answered but leaves the register alone
        s_axi_wstrb <= 4'he;
        wr(MODE, 32'h00, r);
        chk_resp(r, WTIU_RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        rdchk(MODE, 32'h7a);
    endtask

    task automatic t_interval;
        for (int s = 0; s < 4; s++) begin
            wr(MODE, 32'h0, r);
            wr(MODE, 32'(s << 4) | 32'h1, r);
            b = ii_cnt;
            tick(2 * (16 << s) - 1, 1'b0);
            chk(32'(ii_cnt - b), 32'h1);
            tick(1, 1'b0);
            chk(32'(ii_cnt - b), 32'h2);
        end
        // Longest tap, with the top select bit set
        wr(MODE, 32'h0, r);
        wr(MODE, 32'h71, r);
        b = ii_cnt;
        tick(2047, 1'b0);
        chk(32'(ii_cnt - b), 32'h0);
        tick(1, 1'b0);
        chk(32'(ii_cnt - b), 32'h1);
    endtask

    task automatic t_watch;
        for (int p = 3; p > 1; p--) begin
            wr(MODE, 32'h0, r);
            wr(MODE, 32'(p << 2) | 32'h3, r);
            b = wi_cnt;
            tick((p == 3 ? 16 : 32) - 1, 1'b0);
            chk(32'(wi_cnt - b), 32'h0);
            tick(1, 1'b0);
            chk(32'(wi_cnt - b), 32'h1);
        end
        wr(MODE, 32'h0, r);
        wr(MODE, 32'h3, r);
        tick(512, 1'b0);
        rdchk(STAT, 32'h30a00);
    endtask

    task automatic t_runclr;
        wr(MODE, 32'h0, r);
        wr(MODE, 32'h0b, r);
        b = ii_cnt;
        tick(20, 1'b0);
        rdchk(STAT, 32'h3a014);
        wr(WTIU_CLR_ADDR, 32'h02, r);
        rdchk(STAT, 32'h10014);
        tick(12, 1'b0);
        rdchk(STAT, 32'h10020);
        chk(32'(ii_cnt - b), 32'h2);
        // Counter_run is already low, so dropping enable cannot shift the watch
        wr(WTIU_CLR_ADDR, 32'h01, r);
        rdchk(STAT, 32'h0);
    endtask

    task automatic t_source;
        wr(MODE, 32'h0, r);
        wr(MODE, 32'h81, r);
        @(posedge aclk);
        rate_timer_enable <= 1'b1;
        tick(5, 1'b1);
        rdchk(STAT, 32'h50005);
        tick(3, 1'b0);
        rdchk(STAT, 32'h50005);
        wr(MODE, 32'h0, r);
        wr(MODE, 32'h01, r);
        tick(3, 1'b1);
        rdchk(STAT, 32'h10000);
        tick(2, 1'b0);
        rdchk(STAT, 32'h10002);
    endtask

    task automatic print_verdict;
        $display("Comparisons %0d, errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        {aresetn, subclk, brg_clk, rate_timer_enable, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awprot, s_axi_arprot} = '0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        s_axi_wstrb = 4'hf;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
        t_regs;
        t_interval;
        t_watch;
        t_runclr;
        t_source;
        print_verdict;
    end

    initial begin
        repeat (40000) @(posedge aclk);
        error_cnt++;
        print_verdict;
    end
endmodule

bind wtiu_top wtiu_assertions u_chk (.*);
